// ==== inc/pfs_pkg.sv ====
// Shared constants and types for the pin 3 mux and frame trigger control block
package pfs_pkg;

  // Bus geometry and register data width
  localparam int unsigned PFS_ADDR_W = 8;
  localparam int unsigned PFS_REG_W  = 8;

  // Register indices; byte address is four times the index
  localparam logic [7:0] PFS_IDX_PIN3_CTL   = 8'h13;
  localparam logic [7:0] PFS_IDX_RSVD_FIRST = 8'h14;
  localparam logic [7:0] PFS_IDX_RSVD_LAST  = 8'h17;
  localparam logic [7:0] PFS_IDX_FRAME_PULSE_CONTROL     = 8'h18;
  localparam logic [7:0] PFS_IDX_HIGH_1     = 8'h19;
  localparam logic [7:0] PFS_IDX_HIGH_0     = 8'h1A;
  localparam logic [7:0] PFS_IDX_LOW_1      = 8'h1B;
  localparam logic [7:0] PFS_IDX_LOW_0      = 8'h1C;

  // Values after reset
  localparam logic [7:0] PFS_RST_REG = 8'h00;

  // Field positions of pin3_output_control
  localparam int unsigned PFS_SEL_LSB = 5;
  localparam int unsigned PFS_SRC_LSB = 2;
  localparam int unsigned PFS_VAL_BIT = 1;
  localparam int unsigned PFS_EN_BIT  = 0;

  // Field positions of frame_pulse_control
  localparam int unsigned PFS_MODE_LSB   = 4;
  localparam int unsigned PFS_SINGLE_BIT = 3;
  localparam int unsigned PFS_INIT_BIT   = 2;
  localparam int unsigned PFS_SPLIT_BIT  = 1;
  localparam int unsigned PFS_GENEN_BIT  = 0;

  // Source choices
  localparam logic [2:0] PFS_SRC_RX0 = 3'h0;
  localparam logic [2:0] PFS_SRC_RX1 = 3'h1;
  localparam logic [2:0] PFS_SRC_DEV = 3'h4;

  // Signal choices for a receive port source
  localparam logic [2:0] PFS_SEL_RX_PIN3 = 3'h3;
  localparam logic [2:0] PFS_SEL_RX_LOCK = 3'h4;
  localparam logic [2:0] PFS_SEL_RX_PASS = 3'h5;

  // Signal choices for the device status source
  localparam logic [2:0] PFS_SEL_DEV_LOCAL    = 3'h0;
  localparam logic [2:0] PFS_SEL_DEV_LOCK_OR  = 3'h1;
  localparam logic [2:0] PFS_SEL_DEV_LOCK_AND = 3'h2;
  localparam logic [2:0] PFS_SEL_DEV_PASS_AND = 3'h3;
  localparam logic [2:0] PFS_SEL_DEV_TRIGGER  = 3'h4;

  // Frame trigger source modes
  localparam logic [3:0] PFS_MODE_BC0     = 4'h0;
  localparam logic [3:0] PFS_MODE_BC1     = 4'h1;
  localparam logic [2:0] PFS_MODE_REF_TOP = 3'h3;
  localparam logic [1:0] PFS_MODE_EXT_TOP = 2'h2;

  // Pin synchroniser depth
  localparam int unsigned PFS_SYNC_STAGES = 2;

  // Generator states
  typedef enum logic [2:0] {
    PFS_GEN_IDLE,
    PFS_GEN_RUN_HIGH,
    PFS_GEN_RUN_LOW,
    PFS_GEN_SHOT_HIGH,
    PFS_GEN_SHOT_WAIT
  } pfs_gen_state_e;

  // Byte address of a register index
  function automatic logic [PFS_ADDR_W-1:0] pfs_byte_addr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction

endpackage

// ==== rtl/pfs_pulse_gen.sv ====
// Frame trigger period generator counting ticks of the chosen time base
`timescale 1ns/1ns
module pfs_pulse_gen
  import pfs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pclken,
  input  wire logic        tick,
  input  wire logic        allow,
  input  wire logic        run,
  input  wire logic        shot,
  input  wire logic        split_mode,
  input  wire logic        start_level,
  input  wire logic [15:0] high_count,
  input  wire logic [15:0] low_count,
  input  wire logic [23:0] half_count,
  output logic             level,
  output logic             busy
);

  pfs_gen_state_e state;
  pfs_gen_state_e next_state;
  logic [23:0]    cnt;
  logic [23:0]    next_cnt;
  logic           next_level;
  logic [23:0]    high_target;
  logic [23:0]    low_target;
  logic           phase_high;
  logic           phase_done;

  // Phase lengths: one shared count or separate high and low counts
  always_comb
  begin
    high_target = split_mode ? half_count : {8'h00, high_count};
    low_target  = split_mode ? half_count : {8'h00, low_count};
    phase_high  = (state == PFS_GEN_RUN_HIGH) || (state == PFS_GEN_SHOT_HIGH);
    phase_done  = tick && (cnt == (phase_high ? high_target : low_target));
  end

  // Next state, counter and output level
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    next_level = level;
    if (!allow)
    begin
      next_state = PFS_GEN_IDLE;
      next_cnt   = 24'h000000;
      next_level = start_level;
    end
    else
    begin
      case (state)
        PFS_GEN_IDLE:
        begin
          // idle level is the start level
          next_level = start_level;
          next_cnt   = 24'h000000;
          if (run)
          begin
            next_state = start_level ? PFS_GEN_RUN_HIGH : PFS_GEN_RUN_LOW;
          end
          else if (shot)
          begin
            next_state = PFS_GEN_SHOT_HIGH;
            next_level = 1'b1;
          end
        end
        PFS_GEN_RUN_HIGH, PFS_GEN_RUN_LOW:
        begin
          if (!run)
          begin
            next_state = PFS_GEN_IDLE;
            next_level = start_level;
            next_cnt   = 24'h000000;
          end
          else if (phase_done)
          begin
            next_cnt   = 24'h000000;
            next_state = phase_high ? PFS_GEN_RUN_LOW : PFS_GEN_RUN_HIGH;
            next_level = !phase_high;
          end
          else if (tick)
          begin
            next_cnt = cnt + 24'h000001;
          end
        end
        PFS_GEN_SHOT_HIGH:
        begin
          if (phase_done)
          begin
            next_cnt   = 24'h000000;
            next_state = PFS_GEN_SHOT_WAIT;
            next_level = 1'b0;
          end
          else if (tick)
          begin
            next_cnt = cnt + 24'h000001;
          end
        end
        PFS_GEN_SHOT_WAIT:
        begin
          // low phase must elapse before a new pulse
          if (phase_done)
          begin
            next_cnt   = 24'h000000;
            next_state = PFS_GEN_IDLE;
            next_level = start_level;
          end
          else if (tick)
          begin
            next_cnt = cnt + 24'h000001;
          end
        end
        default:
        begin
          next_state = PFS_GEN_IDLE;
        end
      endcase
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= PFS_GEN_IDLE;
      cnt   <= 24'h000000;
      level <= 1'b0;
      busy  <= 1'b0;
    end
    else if (pclken)
    begin
      state <= next_state;
      cnt   <= next_cnt;
      level <= next_level;
      busy  <= (next_state != PFS_GEN_IDLE);
    end
  end

endmodule // pfs_pulse_gen

// ==== rtl/pfs_top.sv ====
// APB register block, pin 3 output mux and frame trigger control
//
// Contract
// - Source choice 000 is port 0, 001 port 1, 100 device status.
// - Port source: 000-011 remote pins, 100 lock, 101 pass.
// - Status source: local bit, lock OR, lock AND, pass AND, frame trigger.
// - Pin driven only while drive enable is 1; local choice shows stored level.
// - Mode 0000/0001 use back-channel clocks, 011x the reference clock.
// - Modes 1000-1011 take trigger from pins 0-3; others reserved.
// - Writing 1 to bit 3 makes exactly one frame trigger pulse; here only in internal modes, with continuous enable 0 and the generator idle.
// - After a single pulse, wait full duration before another.
// - Single pulse bit clears itself and always reads 0.
// - Split mode 0 uses high and low counts, 1 one 24-bit count.
// - Programmed value N gives a phase of N plus one ticks.
// - Start level bit sets trigger level before generation starts.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module pfs_top
  import pfs_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  pclken,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [PFS_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [3:0]            rx0_remote_pins,
  input  wire logic [3:0]            rx1_remote_pins,
  input  wire logic [1:0]            rx_lock,
  input  wire logic [1:0]            rx_pass,
  input  wire logic [1:0]            rx_port_enable,
  input  wire logic [1:0]            bc_frame_tick,
  input  wire logic                  ref_clk_tick,
  input  wire logic [3:0]            gpio_in,
  output logic                       pin3_out,
  output logic                       pin3_oe,
  output logic                       frame_trigger
);

  // Register fields
  logic [2:0]  pin3_signal_choice;
  logic [2:0]  pin3_source_choice;
  logic        pin3_local_level;
  logic        pin3_drive_enable;
  logic [3:0]  frame_pulse_source_mode;
  logic        one_shot_request;
  logic        pulse_start_level;
  logic        period_split_mode;
  logic        continuous_pulse_enable;
  logic [15:0] pulse_high_count;
  logic [15:0] pulse_low_count;
  logic [2:0]  next_signal_choice;
  logic [2:0]  next_source_choice;
  logic        next_local_level;
  logic        next_drive_enable;
  logic [3:0]  next_source_mode;
  logic        next_one_shot;
  logic        next_start_level;
  logic        next_split_mode;
  logic        next_cont_enable;
  logic [15:0] next_high_count;
  logic [15:0] next_low_count;

  // Bus answer
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_en;
  logic        setup;
  logic [7:0]  rd_byte;
  logic        hit;

  // Pin synchroniser and outputs
  logic [3:0]  gpio_meta;
  logic [3:0]  gpio_sync;
  logic        next_pin3_out;
  logic        next_pin3_oe;
  logic        next_trigger;

  // Frame trigger source decode
  logic        mode_internal;
  logic        mode_external;
  logic        gen_tick;
  logic        gen_level;
  logic        gen_busy;
  logic        trig_level;
  logic [3:0]  rx_pins;
  logic        rx_level;
  logic        dev_level;

  // Register read decode by index, shared by setup-phase read path
  function automatic logic [8:0] reg_read(input logic [PFS_ADDR_W-1:0] addr);
    logic [8:0] r;
    r = {1'b0, PFS_RST_REG};
    if (addr == pfs_byte_addr(PFS_IDX_PIN3_CTL))
    begin
      r = {1'b1, pin3_signal_choice, pin3_source_choice, pin3_local_level,
           pin3_drive_enable};
    end
    else if (addr[1:0] == 2'b00 && addr[7:2] >= PFS_IDX_RSVD_FIRST[5:0]
             && addr[7:2] <= PFS_IDX_RSVD_LAST[5:0])
    begin
      r = {1'b1, PFS_RST_REG};
    end
    else if (addr == pfs_byte_addr(PFS_IDX_FRAME_PULSE_CONTROL))
    begin
      // single pulse bit reads as 0
      r = {1'b1, frame_pulse_source_mode, 1'b0, pulse_start_level,
           period_split_mode, continuous_pulse_enable};
    end
    else if (addr == pfs_byte_addr(PFS_IDX_HIGH_1))
    begin
      r = {1'b1, pulse_high_count[15:8]};
    end
    else if (addr == pfs_byte_addr(PFS_IDX_HIGH_0))
    begin
      r = {1'b1, pulse_high_count[7:0]};
    end
    else if (addr == pfs_byte_addr(PFS_IDX_LOW_1))
    begin
      r = {1'b1, pulse_low_count[15:8]};
    end
    else if (addr == pfs_byte_addr(PFS_IDX_LOW_0))
    begin
      r = {1'b1, pulse_low_count[7:0]};
    end
    return r;
  endfunction

  // Bus phases; answer is prepared in the setup cycle, so no wait states
  always_comb
  begin
    setup        = psel && !penable;
    wr_en        = psel && penable && pwrite && pready;
    {hit, rd_byte} = reg_read(paddr);
    next_pready  = setup;
    next_pslverr = setup && !hit;
    next_prdata  = (setup && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
  end

  // Register write decode
  always_comb
  begin
    next_signal_choice = pin3_signal_choice;
    next_source_choice = pin3_source_choice;
    next_local_level   = pin3_local_level;
    next_drive_enable  = pin3_drive_enable;
    next_source_mode   = frame_pulse_source_mode;
    next_one_shot      = 1'b0;
    next_start_level   = pulse_start_level;
    next_split_mode    = period_split_mode;
    next_cont_enable   = continuous_pulse_enable;
    next_high_count    = pulse_high_count;
    next_low_count     = pulse_low_count;
    if (wr_en && paddr == pfs_byte_addr(PFS_IDX_PIN3_CTL))
    begin
      next_signal_choice = pwdata[PFS_SEL_LSB +: 3];
      next_source_choice = pwdata[PFS_SRC_LSB +: 3];
      next_local_level   = pwdata[PFS_VAL_BIT];
      next_drive_enable  = pwdata[PFS_EN_BIT];
    end
    else if (wr_en && paddr == pfs_byte_addr(PFS_IDX_FRAME_PULSE_CONTROL))
    begin
      next_source_mode = pwdata[PFS_MODE_LSB +: 4];
      next_one_shot    = pwdata[PFS_SINGLE_BIT];
      next_start_level = pwdata[PFS_INIT_BIT];
      next_split_mode  = pwdata[PFS_SPLIT_BIT];
      next_cont_enable = pwdata[PFS_GENEN_BIT];
    end
    else if (wr_en && paddr == pfs_byte_addr(PFS_IDX_HIGH_1))
    begin
      next_high_count[15:8] = pwdata[7:0];
    end
    else if (wr_en && paddr == pfs_byte_addr(PFS_IDX_HIGH_0))
    begin
      next_high_count[7:0] = pwdata[7:0];
    end
    else if (wr_en && paddr == pfs_byte_addr(PFS_IDX_LOW_1))
    begin
      next_low_count[15:8] = pwdata[7:0];
    end
    else if (wr_en && paddr == pfs_byte_addr(PFS_IDX_LOW_0))
    begin
      next_low_count[7:0] = pwdata[7:0];
    end
  end

  // Frame trigger source: internal time base or a synchronised pin
  always_comb
  begin
    mode_internal = (frame_pulse_source_mode == PFS_MODE_BC0)
                 || (frame_pulse_source_mode == PFS_MODE_BC1)
                 || (frame_pulse_source_mode[3:1] == PFS_MODE_REF_TOP);
    mode_external = (frame_pulse_source_mode[3:2] == PFS_MODE_EXT_TOP);
    if (frame_pulse_source_mode == PFS_MODE_BC0)
    begin
      gen_tick = bc_frame_tick[0];
    end
    else if (frame_pulse_source_mode == PFS_MODE_BC1)
    begin
      gen_tick = bc_frame_tick[1];
    end
    else
    begin
      gen_tick = ref_clk_tick;
    end
    // reserved modes hold the trigger low
    if (mode_external)
    begin
      trig_level = gpio_sync[frame_pulse_source_mode[1:0]];
    end
    else if (mode_internal)
    begin
      trig_level = gen_level;
    end
    else
    begin
      trig_level = 1'b0;
    end
  end

  // Generator; a single pulse is honoured only with continuous enable clear
  pfs_pulse_gen u_gen (
    .pclk        (pclk),
    .presetn     (presetn),
    .pclken      (pclken),
    .tick        (gen_tick),
    .allow       (mode_internal),
    .run         (continuous_pulse_enable),
    // relies on continuous enable being 0
    .shot        (one_shot_request && !continuous_pulse_enable && !gen_busy),
    .split_mode  (period_split_mode),
    .start_level (pulse_start_level),
    .high_count  (pulse_high_count),
    .low_count   (pulse_low_count),
    .half_count  ({pulse_high_count[7:0], pulse_low_count}),
    .level       (gen_level),
    .busy        (gen_busy)
  );

  // Pin 3 output mux
  always_comb
  begin
    rx_pins = (pin3_source_choice == PFS_SRC_RX1) ? rx1_remote_pins : rx0_remote_pins;
    // per-port signal choice, reserved codes low
    if (pin3_signal_choice <= PFS_SEL_RX_PIN3)
    begin
      rx_level = rx_pins[pin3_signal_choice[1:0]];
    end
    else if (pin3_signal_choice == PFS_SEL_RX_LOCK)
    begin
      rx_level = (pin3_source_choice == PFS_SRC_RX1) ? rx_lock[1] : rx_lock[0];
    end
    else if (pin3_signal_choice == PFS_SEL_RX_PASS)
    begin
      rx_level = (pin3_source_choice == PFS_SRC_RX1) ? rx_pass[1] : rx_pass[0];
    end
    else
    begin
      rx_level = 1'b0;
    end
    // status choices; AND over no enabled port reads low
    case (pin3_signal_choice)
      PFS_SEL_DEV_LOCAL:    dev_level = pin3_local_level;
      PFS_SEL_DEV_LOCK_OR:  dev_level = |(rx_lock & rx_port_enable);
      PFS_SEL_DEV_LOCK_AND: dev_level = (&(rx_lock | ~rx_port_enable)) && |rx_port_enable;
      PFS_SEL_DEV_PASS_AND: dev_level = (&(rx_pass | ~rx_port_enable)) && |rx_port_enable;
      PFS_SEL_DEV_TRIGGER:  dev_level = trig_level;
      default:              dev_level = 1'b0;
    endcase
    if (pin3_source_choice == PFS_SRC_RX0 || pin3_source_choice == PFS_SRC_RX1)
    begin
      next_pin3_out = rx_level;
    end
    else if (pin3_source_choice == PFS_SRC_DEV)
    begin
      next_pin3_out = dev_level;
    end
    else
    begin
      next_pin3_out = 1'b0;
    end
    next_pin3_oe = pin3_drive_enable;
    next_trigger = trig_level;
  end

  // Registers, bus answer, synchroniser and outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin3_signal_choice      <= 3'h0;
      pin3_source_choice      <= 3'h0;
      pin3_local_level        <= 1'b0;
      pin3_drive_enable       <= 1'b0;
      frame_pulse_source_mode <= 4'h0;
      one_shot_request        <= 1'b0;
      pulse_start_level       <= 1'b0;
      period_split_mode       <= 1'b0;
      continuous_pulse_enable <= 1'b0;
      pulse_high_count        <= 16'h0000;
      pulse_low_count         <= 16'h0000;
      prdata                  <= 32'h00000000;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
      gpio_meta               <= 4'h0;
      gpio_sync               <= 4'h0;
      pin3_out                <= 1'b0;
      pin3_oe                 <= 1'b0;
      frame_trigger           <= 1'b0;
    end
    else if (pclken)
    begin
      pin3_signal_choice      <= next_signal_choice;
      pin3_source_choice      <= next_source_choice;
      pin3_local_level        <= next_local_level;
      pin3_drive_enable       <= next_drive_enable;
      frame_pulse_source_mode <= next_source_mode;
      one_shot_request        <= next_one_shot;
      pulse_start_level       <= next_start_level;
      period_split_mode       <= next_split_mode;
      continuous_pulse_enable <= next_cont_enable;
      pulse_high_count        <= next_high_count;
      pulse_low_count         <= next_low_count;
      prdata                  <= next_prdata;
      pready                  <= next_pready;
      pslverr                 <= next_pslverr;
      gpio_meta               <= gpio_in;
      gpio_sync               <= gpio_meta; // Only reader of the first stage
      pin3_out                <= next_pin3_out;
      pin3_oe                 <= next_pin3_oe;
      frame_trigger           <= next_trigger;
    end
  end

endmodule // pfs_top

// ==== verif/pfs_pins_model.sv ====
// External pin model for the general-purpose pins
`timescale 1ns/1ns
module pfs_pins_model
(
  input  wire logic       pin3_out,
  input  wire logic       pin3_oe,
  input  wire logic [3:0] ext_drive,
  output logic [3:0]      gpio_in
);
  // Pin 3 shows the device level while driven, else the outside level
  assign gpio_in = {pin3_oe ? pin3_out : ext_drive[3], ext_drive[2:0]};
endmodule // pfs_pins_model

// ==== verif/pfs_top_asserts.sv ====
// Port checker for the bus, pin 3 and frame trigger outputs
`timescale 1ns/1ns
module pfs_top_asserts
  import pfs_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  pclken,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [PFS_ADDR_W-1:0] paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  pin3_out,
  input wire logic                  pin3_oe,
  input wire logic                  frame_trigger
);
  // Completed write to the pin control word
  logic pin_wr;
  assign pin_wr = psel && penable && pready && pwrite && paddr == 8'h4C;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_after_setup_a:
    assert property (psel && !penable && pclken |=> pready) else $error("no answer");
  ready_single_a:
    assert property (pready && pclken |=> !pready) else $error("long answer");
  err_with_ready_a:
    assert property (pslverr |-> pready && prdata == 32'h0) else $error("stray error");
  idle_data_a:
    assert property (!pready |-> prdata == 32'h0) else $error("data while idle");
  oneshot_reads_a:
    assert property (pready && !pwrite && paddr == 8'h60 |-> !prdata[3])
    else $error("one shot bit read high");
  drive_on_a:
    assert property ($rose(pin3_oe) |-> $past(pin_wr && pwdata[0], 2))
    else $error("drive without enable");
  drive_off_a:
    assert property ($fell(pin3_oe) |-> $past(pin_wr && !pwdata[0], 2))
    else $error("drive dropped");
  reset_quiet_a:
    assert property (disable iff (1'b0) !presetn |-> !pin3_oe && !pin3_out && !frame_trigger)
    else $error("outputs active in reset");
  release_quiet_a:
    assert property ($rose(presetn) |-> !pin3_oe && !frame_trigger && !pready)
    else $error("outputs active after reset");
endmodule // pfs_top_asserts

bind pfs_top pfs_top_asserts pfs_top_asserts_inst (.pclk, .presetn, .pclken, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pin3_out, .pin3_oe, .frame_trigger);

// ==== verif/tb.sv ====
// Self-checking bench for the pin 3 mux and frame trigger block
`timescale 1ns/1ns
module tb;
  import pfs_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b1, pclken = 1'b1, ref_clk_tick = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, err, pin3_out, pin3_oe, frame_trigger;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  rx0_remote_pins = 4'hA, rx1_remote_pins = 4'h5, gpio_in, ext_drive = 4'h0;
  logic [1:0]  rx_lock = 2'b01, rx_pass = 2'b11, rx_port_enable = 2'b11, bc_frame_tick = 2'b00;
  int          num_errors = 0, samples_checked = 0, cycles = 0, hi_cnt = 0, b, n;

  pfs_top pfs_top_inst (.pclk, .presetn, .pclken, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx0_remote_pins, .rx1_remote_pins, .rx_lock, .rx_pass,
    .rx_port_enable, .bc_frame_tick, .ref_clk_tick, .gpio_in, .pin3_out, .pin3_oe,
    .frame_trigger);
  pfs_pins_model pfs_pins_model_inst (.pin3_out, .pin3_oe, .ext_drive, .gpio_in);

  // 20 MHz clock
  always #25 pclk = ~pclk;

  // Cycle count, high-cycle tally and hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    hi_cnt <= hi_cnt + int'(frame_trigger === 1'b1);
    if (cycles == 5000)
    begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end

  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask

  // Length of the next whole high run; a run already under way is skipped
  task automatic hi_len(output int m);
    logic z;
    z = 1'b0;
    m = 0;
    repeat (60)
    begin
      @(posedge pclk);
      if (frame_trigger === 1'b1)
        m = m + int'(z);
      else if (m > 0)
        break;
      else
        z = 1'b1;
    end
  endtask

  // Expected pin level with local level 1 and an idle low trigger
  function automatic logic pin_exp(input logic [2:0] src, input logic [2:0] sel);
    logic [3:0] p;
    p = src[0] ? rx1_remote_pins : rx0_remote_pins;
    if (src == 3'h4)
      case (sel)
        3'h0: return 1'b1;
        3'h1: return |(rx_lock & rx_port_enable);
        3'h2: return (rx_lock & rx_port_enable) == rx_port_enable && |rx_port_enable;
        3'h3: return (rx_pass & rx_port_enable) == rx_port_enable && |rx_port_enable;
        default: return 1'b0;
      endcase
    if (src > 3'h1 || sel > 3'h5)
      return 1'b0;
    return sel[2] ? (sel[0] ? rx_pass[src[0]] : rx_lock[src[0]]) : p[sel[1:0]];
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    // Reset edge at time zero so every flop is cleared before the first clock
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h4C, 8'h00);
    chk("pin ctl reset", 32'h0, rd);
    apb(1'b0, 8'h60, 8'h00);
    chk("frame ctl reset", 32'h0, rd);
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped error", 32'h1, err);
    apb(1'b1, 8'h50, 8'hFF);
    apb(1'b0, 8'h50, 8'h00);
    chk("reserved read", 32'h0, rd);
    for (int s = 0; s < 8; s++)
      for (int c = 0; c < 8; c++)
      begin
        apb(1'b1, 8'h4C, {c[2:0], s[2:0], 2'b11});
        repeat (2) @(posedge pclk);
        chk("pin level", pin_exp(s[2:0], c[2:0]), pin3_out);
        chk("pin drive", 32'h1, pin3_oe);
      end
    // Only port 0 enabled: lock AND follows that port alone
    rx_port_enable <= 2'b01;
    apb(1'b1, 8'h4C, 8'h53);
    repeat (2) @(posedge pclk);
    chk("lock and", 32'h1, pin3_out);
    apb(1'b1, 8'h4C, 8'h11);
    repeat (2) @(posedge pclk);
    chk("local level", 32'h0, pin3_out);
    apb(1'b1, 8'h4C, 8'h10);
    repeat (2) @(posedge pclk);
    chk("pin released", 32'h0, pin3_oe);
    // Single pulse, with a second request landing inside it
    apb(1'b1, 8'h68, 8'h02);
    apb(1'b1, 8'h70, 8'h01);
    b = hi_cnt;
    apb(1'b1, 8'h60, 8'h68);
    apb(1'b1, 8'h60, 8'h68);
    apb(1'b0, 8'h60, 8'h00);
    chk("one shot read", 32'h60, rd);
    repeat (30) @(posedge pclk);
    chk("one shot width", 32'h3, hi_cnt - b);
    apb(1'b1, 8'h60, 8'h61);
    hi_len(n);
    chk("split high", 32'h3, n);
    apb(1'b1, 8'h60, 8'h60);
    apb(1'b1, 8'h68, 8'h00);
    apb(1'b1, 8'h60, 8'h63);
    hi_len(n);
    chk("even high", 32'h2, n);
    apb(1'b1, 8'h60, 8'h21);
    repeat (4) @(posedge pclk);
    b = hi_cnt;
    repeat (20) @(posedge pclk);
    chk("reserved mode", 32'h0, hi_cnt - b);
    // Back-channel time bases: only the chosen port's ticks advance the phases
    bc_frame_tick <= 2'b10;
    apb(1'b1, 8'h60, 8'h11);
    hi_len(n);
    chk("port 1 ticks", 32'h1, n);
    apb(1'b1, 8'h60, 8'h00);
    apb(1'b1, 8'h60, 8'h01);
    repeat (4) @(posedge pclk);
    b = hi_cnt;
    repeat (20) @(posedge pclk);
    chk("port 0 idle", 32'h0, hi_cnt - b);
    bc_frame_tick <= 2'b01;
    hi_len(n);
    chk("port 0 ticks", 32'h1, n);
    apb(1'b1, 8'h60, 8'h04);
    repeat (4) @(posedge pclk);
    chk("start level", 32'h1, frame_trigger);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h60, {2'b10, i[1:0], 4'h0});
      ext_drive <= 4'h1 << i;
      repeat (6) @(posedge pclk);
      chk("external high", 32'h1, frame_trigger);
      ext_drive <= ~(4'h1 << i);
      repeat (6) @(posedge pclk);
      chk("external low", 32'h0, frame_trigger);
    end
    stop_test();
  end
endmodule // tb
